// ===== core/pmr_pkg.sv
// Constants for the management register slice, registers 5 to 18.
package pmr_pkg;
   // ==========================================================
   // Register addresses on the management interface.
   localparam logic [4:0] PMR_ADDR_LPA = 5'h05;
   localparam logic [4:0] PMR_ADDR_EXP = 5'h06;
   localparam logic [4:0] PMR_ADDR_IEEE_LO = 5'h08;
   localparam logic [4:0] PMR_ADDR_IEEE_HI = 5'h0F;
   localparam logic [4:0] PMR_ADDR_STAT = 5'h10;
   localparam logic [4:0] PMR_ADDR_SPEC = 5'h11;
   localparam logic [4:0] PMR_ADDR_RSVD = 5'h12;
   // ==========================================================
   // Field positions.
   localparam int PMR_LPA_ACK = 14;
   localparam int PMR_EXP_PDF = 4;
   localparam int PMR_EXP_LPNP = 3;
   localparam int PMR_EXP_NPA = 2;
   localparam int PMR_EXP_PR = 1;
   localparam int PMR_EXP_LPAN = 0;
   localparam int PMR_STAT_RPD_DIS = 13;
   localparam int PMR_STAT_SYNC = 11;
   localparam int PMR_STAT_PD100 = 10;
   localparam int PMR_STAT_PD10 = 9;
   localparam int PMR_STAT_POL = 8;
   localparam int PMR_STAT_SPEED = 1;
   localparam int PMR_STAT_DUPLEX = 0;
   // ==========================================================
   // Reset values, status write mask and zero word.
   localparam logic [15:0] PMR_STAT_RW_RESET = 16'h2000;
   localparam logic [15:0] PMR_SPEC_RESET = 16'h0000;
   localparam logic [15:0] PMR_STAT_RW_MASK = 16'hF000;
   localparam logic [15:0] PMR_ZERO = 16'h0000;
endpackage

// ===== core/pmr_regs.sv
// Management register slice of a 10/100 physical layer, registers 5 to 18.
// Operation
// - Partner ability shows received base page.
// - Bit 14 set once advertisement received.
// - Parallel detection fault latches, clears on read.
// - Partner next page and autoneg ability shown.
// - Local next page ability shown read-only.
// - Page received latches, clears on read.
// - Registers 8 to 15, 18 read zero.
// - Bit 13 disables automatic reduced power down.
// - Bit 11 shows 100 deserializer sync.
// - Bits 10, 9 show unit power-down.
// - Bit 8 shows 10 Mbps polarity.
// - Bits 6:2 return sampled PHY address.
// - Bits 1, 0 give speed and duplex.
// - Scrambler and 4B/5B bypass controls.
// - Force H and 34 test patterns.
// - Force 100 Mbps link valid.
// - Symbol error enable, carrier sense disable.
// - Dynamic power-down disable, autoneg loopback.
// - Tri-state the line transmit driver.
// - Force reversed polarity, disable auto polarity.
// - Squelch test disable, extended squelch enable.
// - Link integrity disable, jabber disable.
`timescale 1ns/1ns
`default_nettype none
module pmr_regs
   import pmr_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Management access from the serial interface engine.
   input wire logic [4:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   // Auto-negotiation status from the negotiation engine.
   input wire logic [15:0] lp_base_page,
   input wire logic lp_page_acked,
   input wire logic lp_next_page_able,
   input wire logic lp_autoneg_able,
   input wire logic local_next_page_able,
   input wire logic page_received_evt,
   input wire logic par_det_fault_evt,
   // Physical layer status.
   input wire logic rx_deser_in_sync,
   input wire logic pd_100_state,
   input wire logic pd_10_state,
   input wire logic rx_pol_reversed,
   input wire logic [4:0] phy_address,
   input wire logic speed_100,
   input wire logic full_duplex,
   // Controls to the datapath.
   output logic rpd_disable,
   output logic scrambler_bypass,
   output logic coding_bypass,
   output logic force_h_pattern,
   output logic force_34_pattern,
   output logic force_link_valid,
   output logic symbol_err_enable,
   output logic crs100_disable,
   output logic dyn_pd_disable,
   output logic autoneg_loopback,
   output logic tx_tristate,
   output logic force_pol_rev,
   output logic auto_pol_disable,
   output logic squelch_disable,
   output logic ext_squelch_enable,
   output logic link_disable,
   output logic jabber_disable
);
   // ==========================================================
   // Storage.
   logic [15:0] stat_rw;
   logic [15:0] spec;
   logic flag_pdf;
   logic flag_pr;

   // Address decode strobes.
   wire logic hit_lpa = (reg_addr == PMR_ADDR_LPA);
   wire logic hit_exp = (reg_addr == PMR_ADDR_EXP);
   wire logic hit_stat = (reg_addr == PMR_ADDR_STAT);
   wire logic hit_spec = (reg_addr == PMR_ADDR_SPEC);
   wire logic rd_exp = reg_rd && hit_exp;

   // Register words as seen on a read.
   wire logic [15:0] lpa_word = {lp_base_page[15], lp_page_acked, lp_base_page[13:0]};
   wire logic [15:0] exp_word = {11'h000, flag_pdf, lp_next_page_able, local_next_page_able,
                                 flag_pr, lp_autoneg_able};
   wire logic [15:0] stat_word = {stat_rw[15:12], rx_deser_in_sync, pd_100_state, pd_10_state,
                                  rx_pol_reversed, 1'b0, phy_address, speed_100,
                                  full_duplex};

   // Read multiplexer; unmapped and reserved addresses return zero.
   logic [15:0] next_rdata;
   always_comb
   begin
      if (hit_lpa)
         next_rdata = lpa_word;
      else if (hit_exp)
         next_rdata = exp_word;
      else if (hit_stat)
         next_rdata = stat_word;
      else if (hit_spec)
         next_rdata = spec;
      else
         next_rdata = PMR_ZERO;
   end

   // Read data register, loaded on each read.
   always_ff @(posedge clk)
   begin
      if (rst)
         reg_rdata <= PMR_ZERO;
      else if (reg_rd)
         reg_rdata <= next_rdata;
   end

   // Latched flags: a new event beats the clear of the read.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         flag_pdf <= 1'b0;
         flag_pr <= 1'b0;
      end
      else
      begin
         flag_pdf <= par_det_fault_evt | (flag_pdf & ~rd_exp);
         flag_pr <= page_received_evt | (flag_pr & ~rd_exp);
      end
   end

   // Writable control words.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stat_rw <= PMR_STAT_RW_RESET;
         spec <= PMR_SPEC_RESET;
      end
      else if (reg_wr)
      begin
         if (hit_stat)
            stat_rw <= reg_wdata & PMR_STAT_RW_MASK;
         if (hit_spec)
            spec <= reg_wdata;
      end
   end

   // Control outputs, registered from the control words.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rpd_disable <= PMR_STAT_RW_RESET[PMR_STAT_RPD_DIS];
         {scrambler_bypass, coding_bypass, force_h_pattern, force_34_pattern} <= 4'h0;
         {force_link_valid, symbol_err_enable, crs100_disable, dyn_pd_disable} <= 4'h0;
         {autoneg_loopback, tx_tristate, force_pol_rev, auto_pol_disable} <= 4'h0;
         {squelch_disable, ext_squelch_enable, link_disable, jabber_disable} <= 4'h0;
      end
      else
      begin
         rpd_disable <= stat_rw[PMR_STAT_RPD_DIS];
         {scrambler_bypass, coding_bypass} <= spec[15:14];
         {force_h_pattern, force_34_pattern} <= spec[13:12];
         force_link_valid <= spec[11];
         {symbol_err_enable, crs100_disable} <= spec[10:9];
         {dyn_pd_disable, autoneg_loopback} <= spec[8:7];
         tx_tristate <= spec[6];
         {force_pol_rev, auto_pol_disable} <= spec[5:4];
         {squelch_disable, ext_squelch_enable} <= spec[3:2];
         {link_disable, jabber_disable} <= spec[1:0];
      end
   end
endmodule
`default_nettype wire

// ===== sim/pmr_regs_asserts.sv
// Assertions on the register slice ports.
`timescale 1ns/1ns
`default_nettype none
module pmr_regs_asserts
   import pmr_pkg::*;
(
   // Watched ports.
   input wire logic clk, rst, reg_rd, reg_wr, lp_page_acked, page_received_evt, par_det_fault_evt, rpd_disable,
   input wire logic [4:0] reg_addr,
   input wire logic [15:0] reg_wdata, reg_rdata, lp_base_page
);
   // ==========================================================
   // Checks sample on clk and rest in reset; rx marks an expansion read.
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire rx = reg_rd && reg_addr == PMR_ADDR_EXP;
   rsvd_zero_a: assert property (reg_rd && reg_addr == PMR_ADDR_RSVD |=> reg_rdata == PMR_ZERO) else $error("Bad rsvd.");
   ieee_zero_a: assert property (reg_rd && reg_addr inside {[PMR_ADDR_IEEE_LO:PMR_ADDR_IEEE_HI]} |=>
      reg_rdata == PMR_ZERO) else $error("Bad ieee.");
   partner_view_a: assert property (reg_rd && reg_addr == PMR_ADDR_LPA |=>
      reg_rdata == {$past(lp_base_page[15]), $past(lp_page_acked), $past(lp_base_page[13:0])}) else $error("Bad lpa.");
   rpd_write_a: assert property (reg_wr && reg_addr == PMR_ADDR_STAT |-> ##2 rpd_disable == $past(reg_wdata[13], 2))
      else $error("Bad rpd.");
   page_clear_a: assert property (rx && !page_received_evt ##1 !page_received_evt ##1 rx |=>
      !reg_rdata[PMR_EXP_PR]) else $error("Pr kept.");
   page_latch_a: assert property (page_received_evt ##1 rx |=> reg_rdata[PMR_EXP_PR]) else $error("Pr lost.");
   fault_clear_a: assert property (rx && !par_det_fault_evt ##1 !par_det_fault_evt ##1 rx |=>
      !reg_rdata[PMR_EXP_PDF]) else $error("Pdf kept.");
   fault_latch_a: assert property (par_det_fault_evt ##1 rx |=> reg_rdata[PMR_EXP_PDF]) else $error("Pdf lost.");
endmodule
bind pmr_regs pmr_regs_asserts u_pmr_regs_asserts (.clk(clk), .rst(rst), .reg_rd(reg_rd), .reg_wr(reg_wr),
   .lp_page_acked(lp_page_acked), .page_received_evt(page_received_evt), .par_det_fault_evt(par_det_fault_evt),
   .rpd_disable(rpd_disable), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .lp_base_page(lp_base_page));
`default_nettype wire

// ===== sim/pmr_mm.sv
// Management controller model driving register accesses.
`timescale 1ns/1ns
`default_nettype none
module pmr_mm (
   // Clock and read data in, strobes out.
   input wire logic clk,
   input wire logic [15:0] reg_rdata,
   output var logic reg_rd = 1'b0, reg_wr = 1'b0,
   output var logic [4:0] reg_addr = 5'h00,
   output var logic [15:0] reg_wdata = 16'h0000
);
   // Write for one edge, scramble the released data, wait for the controls.
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk) reg_wr = 1'b0;
      reg_wdata = ~d;
      repeat (2) @(negedge clk);
   endtask
   // Read for one edge, then take the loaded word.
   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk) reg_rd = 1'b0;
      @(negedge clk) d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ===== sim/phy_mgmt_regs_5_to_18_tb_top.sv
// Testbench for the register slice.
`timescale 1ns/1ns
`default_nettype none
module phy_mgmt_regs_5_to_18_tb_top;
   import pmr_pkg::*;
   logic clk = 1'b0, rst = 1'b1, pe = 1'b0, pf = 1'b0;
   logic [15:0] lp = 16'ha5a5, d;
   logic [11:0] st = 12'hb56;
   logic [2:0] x = 3'b101;
   int fails = 0, samples_checked = 0, cyc = 0;
   wire rd, wr, rpd;
   wire [4:0] a;
   wire [15:0] wd, rq, ctl;
   // ==========================================================
   // Device and controller model.
   pmr_regs u_pmr_regs (.clk(clk), .rst(rst), .reg_addr(a), .reg_rd(rd), .reg_wr(wr), .reg_wdata(wd), .reg_rdata(rq),
      .lp_base_page(lp), .lp_page_acked(x[0]), .lp_next_page_able(x[2]), .lp_autoneg_able(x[0]),
      .local_next_page_able(x[1]), .page_received_evt(pe), .par_det_fault_evt(pf), .rx_deser_in_sync(st[11]),
      .pd_100_state(st[10]), .pd_10_state(st[9]), .rx_pol_reversed(st[8]), .phy_address(st[6:2]), .speed_100(st[1]),
      .full_duplex(st[0]), .rpd_disable(rpd), .scrambler_bypass(ctl[15]), .coding_bypass(ctl[14]),
      .force_h_pattern(ctl[13]), .force_34_pattern(ctl[12]), .force_link_valid(ctl[11]), .symbol_err_enable(ctl[10]),
      .crs100_disable(ctl[9]), .dyn_pd_disable(ctl[8]), .autoneg_loopback(ctl[7]), .tx_tristate(ctl[6]),
      .force_pol_rev(ctl[5]), .auto_pol_disable(ctl[4]), .squelch_disable(ctl[3]), .ext_squelch_enable(ctl[2]),
      .link_disable(ctl[1]), .jabber_disable(ctl[0]));
   pmr_mm u_pmr_mm (.clk(clk), .reg_rdata(rq), .reg_rd(rd), .reg_wr(wr), .reg_addr(a), .reg_wdata(wd));
   // Clock and hang guard.
   initial forever #5 clk = ~clk;
   always @(posedge clk)
      if (++cyc > 2000)
      begin
         fails++;
         finish_test();
      end
   // Compare one value.
   task chk(input string n, input logic [15:0] s, e);
      samples_checked++;
      if (s !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   // Report and stop.
   task finish_test;
      $display("Checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Main sequence.
   initial
   begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      chk("rpd", {15'h0000, rpd}, 16'h0001);
      u_pmr_mm.rd(PMR_ADDR_STAT, d);
      chk("stat", d, {4'h2, st});
      u_pmr_mm.wr(PMR_ADDR_LPA, 16'h0000);
      u_pmr_mm.rd(PMR_ADDR_LPA, d);
      chk("lpa", d, {lp[15], x[0], lp[13:0]});
      pe = 1'b1;
      pf = 1'b1;
      @(negedge clk) pe = 1'b0;
      pf = 1'b0;
      u_pmr_mm.rd(PMR_ADDR_EXP, d);
      chk("exp", d, 16'h001b);
      fork
         u_pmr_mm.rd(PMR_ADDR_EXP, d);
         pe = 1'b1;
         @(negedge clk) pe = 1'b0;
      join
      chk("exp", d, 16'h0009);
      u_pmr_mm.rd(PMR_ADDR_EXP, d);
      chk("exp", d, 16'h000b);
      u_pmr_mm.rd(PMR_ADDR_EXP, d);
      chk("exp", d, 16'h0009);
      for (int i = 0; i < 16; i++)
      begin
         u_pmr_mm.wr(PMR_ADDR_SPEC, 16'h0001 << i);
         chk("ctl", ctl, 16'h0001 << i);
      end
      u_pmr_mm.rd(PMR_ADDR_SPEC, d);
      chk("spec", d, 16'h8000);
      u_pmr_mm.wr(PMR_ADDR_STAT, 16'h0fff);
      u_pmr_mm.rd(PMR_ADDR_STAT, d);
      chk("stat", d, {4'h0, st});
      chk("rpd", {15'h0000, rpd}, 16'h0000);
      for (int j = 8; j < 19; j++)
      begin
         u_pmr_mm.wr(5'(j), 16'hffff);
         u_pmr_mm.rd(5'(j), d);
         if (j < 16 || j == 18)
            chk("rsvd", d, 16'h0000);
         else if (j == 16)
            chk("stat", d, {4'hf, st});
         else
            chk("spec", d, 16'hffff);
      end
      chk("ctl", ctl, 16'hffff);
      chk("rpd", {15'h0000, rpd}, 16'h0001);
      finish_test();
   end
endmodule
`default_nettype wire
